/* logic/ppg_pkg.sv */
package ppg_pkg;
   // ---------------------------------------------------------------
   // widths and limits
   // ---------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h0EFFF;
   localparam logic [3:0] MAX_TRIES = 4'hA;
   localparam logic [1:0] PAGE_LAST = 2'h3;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int PULSE_US = 100;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int SETUP_CYC = 4;
   localparam logic [15:0] PULSE_CNT = 16'(PULSE_CYC);
   localparam logic [15:0] SETUP_CNT = 16'(SETUP_CYC);

   // command from the user side
   typedef enum logic [1:0] {
      PPG_CMD_READ = 2'h0,
      PPG_CMD_BYTE = 2'h1,
      PPG_CMD_PAGE = 2'h2
   } ppg_cmd_t;

   typedef struct packed {
      ppg_cmd_t cmd;
      logic [ADDR_W-1:0] addr;
      logic [4*DATA_W-1:0] data;
   } ppg_req_t;

   typedef struct packed {
      logic done;
      logic fail;
      logic [DATA_W-1:0] rdata;
   } ppg_rsp_t;

   // pin group toward the device
   typedef struct packed {
      logic reset_n;
      logic vpp_high;
      logic vpp_on;
      logic chip_sel_n;
      logic out_en_n;
      logic program_strobe_n;
      logic [ADDR_W-1:0] prog_address_bus;
      logic [DATA_W-1:0] prog_data_bus;
      logic data_oe_n;
   } ppg_pins_t;

   typedef enum logic [6:0] {
      PPG_IDLE = 7'h01,
      PPG_LATCH = 7'h02,
      PPG_PULSE = 7'h04,
      PPG_VSET = 7'h08,
      PPG_VCHK = 7'h10,
      PPG_READ = 7'h20,
      PPG_DONE = 7'h40
   } ppg_state_t;
endpackage

/* logic/ppg_host.sv */
`timescale 1ns/1ps
// How it works
// RULE_01: we hold reset low and drive supply to enter programming mode.
// RULE_02: read with read supply, chip select and output enable both low.
// RULE_03: our data driver is released whenever chip select and output enable are both low.
// RULE_04: standby by chip select high; device data then floats.
// RULE_05: page latch: chip select high, strobe high, output enable low per byte.
// RULE_06: after four bytes, one 0.1 ms strobe with chip select and enable high.
// RULE_07: after page write verify with chip select and output enable low.
// RULE_08: failed verify repeats pulse and verify, at most ten attempts.
// RULE_09: byte write: chip select low, enable high, data, one 0.1 ms pulse.
// RULE_10: byte verify keeps chip select low and lowers output enable.
// RULE_11: verify runs with write supply, strobe high, select and enable low.
// RULE_12: strobe stays high outside pulses so shared devices stay untouched.
// RULE_13: addresses above the last valid one are refused with fail.
// RULE_14: read back: reset low, read supply, address first, then read mode.
// RULE_15: erased locations read all ones; blank data needs no programming.
module ppg_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_valid_i,
   input wire ppg_pkg::ppg_req_t req_i,
   input wire logic [ppg_pkg::DATA_W-1:0] prog_data_bus_i,
   output logic req_ready_o,
   output ppg_pkg::ppg_rsp_t rsp_o,
   output ppg_pkg::ppg_pins_t pins_o
);
   import ppg_pkg::*;

   typedef struct packed {
      ppg_state_t st;
      ppg_cmd_t cmd;
      logic [ADDR_W-1:0] addr;
      logic [4*DATA_W-1:0] data;
      logic [1:0] idx;
      logic [3:0] tries;
      logic [15:0] cnt;
      logic [15:0] low_run;
      logic ready;
      ppg_rsp_t rsp;
      ppg_pins_t pins;
      logic [DATA_W-1:0] din_s1;
      logic [DATA_W-1:0] din_s2;
   } ppg_regs_t;

   ppg_regs_t s_reg;
   ppg_regs_t s_next;
   logic [DATA_W-1:0] want;
   logic [ADDR_W-1:0] end_addr;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.din_s1 = prog_data_bus_i;
      s_next.din_s2 = s_reg.din_s1;
      s_next.rsp.done = 1'b0;
      want = s_reg.data[DATA_W*s_reg.idx +: DATA_W];
      end_addr = s_reg.addr + ADDR_W'(s_reg.idx);
      case (s_reg.st)
         PPG_IDLE: begin
            // idle is standby with the bus released
            s_next.pins.chip_sel_n = 1'b1;
            s_next.pins.out_en_n = 1'b1;
            s_next.pins.program_strobe_n = 1'b1;
            s_next.pins.data_oe_n = 1'b1;
            s_next.ready = 1'b1;
            if (req_valid_i && s_reg.ready) begin
               s_next.ready = 1'b0;
               s_next.cmd = req_i.cmd;
               s_next.addr = req_i.addr;
               s_next.data = req_i.data;
               s_next.idx = 2'h0;
               s_next.tries = 4'h0;
               s_next.cnt = SETUP_CNT;
               s_next.rsp.fail = 1'b0;
               // RULE_13: range guard
               if (req_i.addr > ADDR_LAST ||
                   (req_i.cmd == PPG_CMD_PAGE && req_i.addr + 17'h3 > ADDR_LAST)) begin
                  s_next.rsp.fail = 1'b1;
                  s_next.st = PPG_DONE;
               end else if (req_i.cmd == PPG_CMD_READ) begin
                  // RULE_14: read supply, address before read mode
                  s_next.pins.vpp_high = 1'b0;
                  s_next.pins.prog_address_bus = req_i.addr;
                  s_next.st = PPG_READ;
               end else if (req_i.cmd == PPG_CMD_PAGE) begin
                  s_next.pins.vpp_high = 1'b1;
                  s_next.st = PPG_LATCH;
               end else begin
                  // RULE_09: byte setup, select low, enable high, drive data
                  s_next.pins.vpp_high = 1'b1;
                  s_next.pins.chip_sel_n = 1'b0;
                  s_next.pins.prog_address_bus = req_i.addr;
                  s_next.pins.prog_data_bus = req_i.data[DATA_W-1:0];
                  s_next.pins.data_oe_n = 1'b0;
                  s_next.st = PPG_PULSE;
               end
            end
         end
         PPG_LATCH: begin
            // RULE_05: latch one byte per slot of the page
            s_next.pins.chip_sel_n = 1'b1;
            s_next.pins.program_strobe_n = 1'b1;
            s_next.pins.out_en_n = 1'b0;
            s_next.pins.prog_address_bus = end_addr;
            s_next.pins.prog_data_bus = want;
            s_next.pins.data_oe_n = 1'b0;
            if (s_reg.cnt != 16'h0) begin
               s_next.cnt = s_reg.cnt - 16'h1;
            end else if (s_reg.idx != PAGE_LAST) begin
               s_next.idx = s_reg.idx + 2'h1;
               s_next.cnt = SETUP_CNT;
            end else begin
               // RULE_06: data released, enable high before the pulse
               s_next.pins.out_en_n = 1'b1;
               s_next.pins.data_oe_n = 1'b1;
               s_next.idx = 2'h0;
               s_next.cnt = SETUP_CNT;
               s_next.st = PPG_PULSE;
            end
         end
         PPG_PULSE: begin
            if (s_reg.cnt != 16'h0) begin
               s_next.cnt = s_reg.cnt - 16'h1;
            end else if (s_reg.pins.program_strobe_n) begin
               // RULE_06: one pulse of the full width
               s_next.pins.program_strobe_n = 1'b0;
               s_next.cnt = PULSE_CNT - 16'h1;
               s_next.tries = s_reg.tries + 4'h1;
            end else begin
               // RULE_12: strobe returns high right after the pulse
               s_next.pins.program_strobe_n = 1'b1;
               s_next.pins.data_oe_n = 1'b1;
               s_next.idx = 2'h0;
               s_next.cnt = SETUP_CNT;
               s_next.st = PPG_VSET;
            end
         end
         PPG_VSET: begin
            // RULE_07: page verify; RULE_10: byte verify; RULE_11: verify mode
            s_next.pins.chip_sel_n = 1'b0;
            s_next.pins.out_en_n = 1'b0;
            s_next.pins.prog_address_bus = end_addr;
            if (s_reg.cnt != 16'h0) begin
               s_next.cnt = s_reg.cnt - 16'h1;
            end else begin
               s_next.st = PPG_VCHK;
            end
         end
         PPG_VCHK: begin
            s_next.cnt = SETUP_CNT;
            if (s_reg.din_s2 != want) begin
               s_next.pins.out_en_n = 1'b1;
               // RULE_08: retry up to ten attempts
               if (s_reg.tries == MAX_TRIES) begin
                  s_next.rsp.fail = 1'b1;
                  s_next.st = PPG_DONE;
               end else if (s_reg.cmd == PPG_CMD_PAGE) begin
                  s_next.pins.chip_sel_n = 1'b1;
                  s_next.st = PPG_PULSE;
               end else begin
                  s_next.pins.prog_data_bus = want;
                  s_next.pins.data_oe_n = 1'b0;
                  s_next.st = PPG_PULSE;
               end
            end else if (s_reg.cmd == PPG_CMD_PAGE && s_reg.idx != PAGE_LAST) begin
               s_next.idx = s_reg.idx + 2'h1;
               s_next.st = PPG_VSET;
            end else begin
               s_next.st = PPG_DONE;
            end
         end
         PPG_READ: begin
            // RULE_02: read mode after address has settled
            s_next.pins.chip_sel_n = 1'b0;
            s_next.pins.out_en_n = 1'b0;
            if (s_reg.cnt != 16'h0) begin
               s_next.cnt = s_reg.cnt - 16'h1;
            end else if (s_reg.pins.out_en_n == 1'b0) begin
               s_next.rsp.rdata = s_reg.din_s2;
               s_next.st = PPG_DONE;
            end
         end
         PPG_DONE: begin
            // RULE_04: back to standby
            s_next.pins.chip_sel_n = 1'b1;
            s_next.pins.out_en_n = 1'b1;
            s_next.pins.data_oe_n = 1'b1;
            s_next.rsp.done = 1'b1;
            s_next.st = PPG_IDLE;
         end
         default: begin
            s_next.st = PPG_IDLE;
         end
      endcase
      // RULE_03: never drive while the selected device may drive
      // a deselected device floats, so the page latch may drive with enable low
      if (!s_next.pins.out_en_n && !s_next.pins.chip_sel_n) begin
         s_next.pins.data_oe_n = 1'b1;
      end
      // strobe low run length, kept for the pulse width checks
      s_next.low_run = s_next.pins.program_strobe_n ? 16'h0 : s_reg.low_run + 16'h1;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.st <= PPG_IDLE;
         // RULE_01: programming mode held from reset on
         s_reg.pins.reset_n <= 1'b0;
         s_reg.pins.vpp_on <= 1'b1;
         s_reg.pins.chip_sel_n <= 1'b1;
         s_reg.pins.out_en_n <= 1'b1;
         s_reg.pins.program_strobe_n <= 1'b1;
         s_reg.pins.data_oe_n <= 1'b1;
         s_reg.rsp.rdata <= ERASED_BYTE;
         s_reg.din_s1 <= ERASED_BYTE;
         s_reg.din_s2 <= ERASED_BYTE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign req_ready_o = s_reg.ready;
   assign rsp_o = s_reg.rsp;
   assign pins_o = s_reg.pins;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence strobe_fall_s;
      $fell(pins_o.program_strobe_n);
   endsequence

   pulse_width_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
      strobe_fall_s |-> !pins_o.program_strobe_n [*8])
      else $error("program pulse too short");
   pulse_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
      s_reg.low_run <= PULSE_CNT)
      else $error("program pulse too long");
   pulse_len_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
      $rose(pins_o.program_strobe_n) |-> $past(s_reg.low_run) == PULSE_CNT)
      else $error("program pulse not of full width");
   bus_release_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
      !pins_o.out_en_n && !pins_o.chip_sel_n |-> pins_o.data_oe_n)
      else $error("host drives data while device enabled");
   latch_drive_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
      s_reg.st == PPG_LATCH && !pins_o.out_en_n |-> !pins_o.data_oe_n
      && pins_o.chip_sel_n && pins_o.program_strobe_n)
      else $error("page latch without data driven");
   page_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
      !pins_o.program_strobe_n |-> pins_o.out_en_n)
      else $error("output enable low during pulse");
   tries_cap_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
      s_reg.tries <= MAX_TRIES)
      else $error("more than ten attempts");
   range_ok_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
      !pins_o.program_strobe_n |-> pins_o.prog_address_bus <= ADDR_LAST)
      else $error("write outside valid range");
   prog_mode_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
      !pins_o.reset_n && pins_o.vpp_on)
      else $error("programming mode lost");
   read_supply_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
      s_reg.st == PPG_READ |-> !pins_o.vpp_high)
      else $error("read with write supply");
   verify_mode_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
      s_reg.st == PPG_VCHK |-> !pins_o.chip_sel_n && !pins_o.out_en_n
      && pins_o.program_strobe_n)
      else $error("verify outside verify mode");
endmodule

/* tb/ppg_prom_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// behavioural one-time programmable memory seen through its pins
// ---------------------------------------------------------------
module ppg_prom_model (
   input wire logic clk_i,
   input wire ppg_pkg::ppg_pins_t pins_i,
   input wire logic [ppg_pkg::DATA_W-1:0] bus_i,
   input wire logic [3:0] skip_i,
   output logic [ppg_pkg::DATA_W-1:0] data_o,
   output logic drive_o,
   output logic [7:0] pulses_o,
   output logic [15:0] width_o,
   output logic clash_o
);
   import ppg_pkg::*;
   logic [DATA_W-1:0] mem [2**ADDR_W];
   logic [DATA_W-1:0] lat_data [4];
   logic [ADDR_W-1:0] lat_addr [4];
   logic [DATA_W-1:0] prev_bus;
   ppg_pins_t prev;
   logic [15:0] low_cnt;
   logic [3:0] skipped;
   logic prog_mode;

   function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
      return mem[a];
   endfunction

   initial begin
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      pulses_o = 8'h00;
      width_o = 16'h0000;
      clash_o = 1'b0;
      low_cnt = 16'h0000;
      skipped = 4'h0;
   end

   assign prog_mode = !pins_i.reset_n && pins_i.vpp_on;
   assign drive_o = prog_mode && !pins_i.chip_sel_n && !pins_i.out_en_n
      && pins_i.program_strobe_n;
   // pulse count retriggers the lookup after a write lands
   always @(pins_i or pulses_o) begin
      data_o = rd(pins_i.prog_address_bus);
   end

   // cells change only at the end of a full pulse
   always @(posedge clk_i) begin
      clash_o <= clash_o | (drive_o & !pins_i.data_oe_n);
      prev <= pins_i;
      prev_bus <= bus_i;
      low_cnt <= pins_i.program_strobe_n ? 16'h0000 : low_cnt + 16'h0001;
      if (prog_mode && pins_i.vpp_high && pins_i.chip_sel_n && !pins_i.out_en_n
         && pins_i.program_strobe_n) begin
         lat_data[pins_i.prog_address_bus[1:0]] <= bus_i;
         lat_addr[pins_i.prog_address_bus[1:0]] <= pins_i.prog_address_bus;
      end
      if (prog_mode && prev.vpp_high && !prev.program_strobe_n && pins_i.program_strobe_n) begin
         width_o <= low_cnt;
         pulses_o <= pulses_o + 8'h01;
         // short pulses and pulses with output enable low program nothing
         if (low_cnt < PULSE_CNT || !prev.out_en_n) begin
            skipped <= skipped;
         end else if (skipped < skip_i) begin
            skipped <= skipped + 4'h1;
         end else if (prev.chip_sel_n) begin
            for (int k = 0; k < 4; k++) mem[lat_addr[k]] = rd(lat_addr[k]) & lat_data[k];
         end else begin
            mem[prev.prog_address_bus] = rd(prev.prog_address_bus) & prev_bus;
         end
      end
   end
endmodule

/* tb/tb_prom_programming_port.sv */
`timescale 1ns/1ps
module tb_prom_programming_port;
   import ppg_pkg::*;
   logic clk_i;
   logic rst_i;
   logic req_valid_i;
   ppg_req_t req_i;
   logic req_ready_o;
   ppg_rsp_t rsp_o;
   ppg_pins_t pins_o;
   logic [DATA_W-1:0] bus;
   logic [DATA_W-1:0] last_bus;
   logic [DATA_W-1:0] dev_data;
   logic dev_drive;
   logic clash;
   logic [7:0] pulses;
   logic [15:0] width;
   logic [3:0] skip;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;

   // ---------------------------------------------------------------
   // wiring: a floating bus shows the inverse of its last level
   // ---------------------------------------------------------------
   assign bus = !pins_o.data_oe_n ? pins_o.prog_data_bus : dev_drive ? dev_data : ~last_bus;

   ppg_host uut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .prog_data_bus_i(bus), .req_ready_o(req_ready_o), .rsp_o(rsp_o), .pins_o(pins_o));
   ppg_prom_model dev (.clk_i(clk_i), .pins_i(pins_o), .bus_i(bus), .skip_i(skip),
      .data_o(dev_data), .drive_o(dev_drive), .pulses_o(pulses), .width_o(width),
      .clash_o(clash));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // hold the request until ready is sampled, then wait for done
   task automatic go(input ppg_cmd_t cmd, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int i;
      req_valid_i <= 1'b1;
      req_i <= '{cmd: cmd, addr: a, data: d};
      do @(posedge clk_i); while (req_ready_o !== 1'b1);
      req_valid_i <= 1'b0;
      for (i = 0; i < 40000 && rsp_o.done !== 1'b1; i++) @(posedge clk_i);
      check(rsp_o.done, 1'b1);
      @(posedge clk_i);
   endtask

   task automatic read_exp(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      go(PPG_CMD_READ, a, 32'h0);
      check(rsp_o.fail, 1'b0);
      check(rsp_o.rdata, exp);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_blank;
      read_exp(ADDR_LAST, ERASED_BYTE);
      check(pins_o.reset_n, 1'b0);
      check(pins_o.vpp_on, 1'b1);
   endtask

   task automatic t_byte;
      go(PPG_CMD_BYTE, 17'h00010, 32'h0000005A);
      check(rsp_o.fail, 1'b0);
      check(pulses, 8'h01);
      check(width >= PULSE_CNT, 1'b1);
      read_exp(17'h00010, 8'h5A);
   endtask

   // first pulse is ignored by the memory, so one repeat is needed
   task automatic t_retry;
      skip <= 4'h1;
      go(PPG_CMD_BYTE, 17'h00020, 32'h0000003C);
      check(rsp_o.fail, 1'b0);
      check(pulses, 8'h03);
      skip <= 4'h0;
      read_exp(17'h00020, 8'h3C);
   endtask

   task automatic t_page;
      go(PPG_CMD_PAGE, 17'h00100, 32'h44332211);
      check(rsp_o.fail, 1'b0);
      check(pulses, 8'h04);
      for (int k = 0; k < 4; k++) read_exp(17'h00100 + 17'(k), 8'(8'h11 * (k + 1)));
   endtask

   // past the last address nothing is pulsed; a page ending on it is fine
   task automatic t_range;
      go(PPG_CMD_BYTE, 17'h0F000, 32'h00000011);
      check(rsp_o.fail, 1'b1);
      go(PPG_CMD_PAGE, 17'h0EFFE, 32'h11111111);
      check(rsp_o.fail, 1'b1);
      check(pulses, 8'h04);
      go(PPG_CMD_PAGE, 17'h0EFFC, 32'hA0B0C0D0);
      check(rsp_o.fail, 1'b0);
      read_exp(ADDR_LAST, 8'hA0);
      check(clash, 1'b0);
   endtask

   // run length ceiling: four programming passes plus one repeat
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial begin
      rst_i = 1'b1;
      req_valid_i = 1'b0;
      req_i = '0;
      skip = 4'h0;
      last_bus = 8'h00;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      t_blank();
      t_byte();
      t_retry();
      t_page();
      t_range();
      wrap_up();
   end

   always @(posedge clk_i) last_bus <= bus;
endmodule
